// File: sfs_supervisor.sv
// Cabinet serial bus fault supervisor with Wishbone registers
// How it works
// - Bus carries Type-1 messages at 153.6 kbit/s; link logic is outside.
// - Enabled interface units talk only while the run gate is on.
// - Enable bits: 8 terminal units, then detectors, then the monitor.
// - Retry window counts down 0..255 minutes, started by a critical fault.
// - Zero window: a fault latches until reset or operator clear.
// - Nonzero window: fault mode lasts until communication is restored.
// - Window keeps running after recovery; first two faults recover.
// - A third fault inside the window latches until reset or clear.
// - Faults of enabled detectors raise events when reporting is on.
// - Detector faults are dropped when reporting is off.
// - Monitor present, run gate on and table mismatching its card gives fault and flash.
// - Compatibility table holds one bit per channel pair, triangular.
// - Compatible channel pairs may show concurrent indications freely.
// - Each of 16 monitor channels maps to one of 24 outputs.
// - A zero map entry selects identity mapping.
// - Each enabled unit keeps a frame error count and status.
// - Operator clear removes a latched critical fault.
`timescale 1ns/1ps
`default_nettype none
module sfs_supervisor #(
	parameter longint MINUTE_CYCLES = sfs_pkg::MINUTE_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [sfs_pkg::AW-1:0] wb_adr_i,
	input wire logic [sfs_pkg::DW-1:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [sfs_pkg::DW-1:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic comm_fault,
	input wire logic [sfs_pkg::NUM_DET-1:0] det_fault,
	input wire logic [sfs_pkg::NUM_DEV-1:0] frame_err,
	input wire logic [sfs_pkg::NUM_DEV-1:0] unit_ok,
	input wire logic [sfs_pkg::NUM_PAIR-1:0] monitor_card,
	output logic [sfs_pkg::NUM_DEV-1:0] unit_active,
	output logic [sfs_pkg::NUM_DET-1:0] det_event,
	output logic fault_mode,
	output logic fault_latched,
	output logic compat_fault,
	output logic flash_req,
	output logic [sfs_pkg::NUM_PAIR-1:0] compat_table,
	output logic [5*sfs_pkg::NUM_MCH-1:0] channel_out,
	output logic irq
);
	import sfs_pkg::*;

	// Pair index in the upper triangle, i<j
	function automatic logic [6:0] pair_idx(input logic [3:0] i,
		input logic [3:0] j);
		logic [7:0] a;
		logic [7:0] b;
		a = {4'h0, i};
		b = {4'h0, j};
		pair_idx = 7'(a * 8'd15 - ((a * (a - 8'd1)) >> 1) + b - a - 8'd1);
	endfunction : pair_idx

	logic [31:0] ctrl_q;
	logic [NUM_DEV-1:0] enable_q;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [3:0] map_sel_q;
	logic [4:0] map_q [NUM_MCH];
	logic [3:0] ci_q;
	logic [3:0] cj_q;
	logic [NUM_PAIR-1:0] compat_q;
	logic [4:0] err_sel_q;
	logic [ERR_W-1:0] err_cnt_q [NUM_DEV];
	logic clear_cmd;
	logic wr;
	logic rd;
	logic mapped;
	logic [31:0] rdata;
	sfs_state_e state_q;
	logic [7:0] min_left_q;
	logic [39:0] tick_q;
	logic [1:0] faults_q;
	logic comm_fault_q;
	logic fault_rise;
	logic latch_evt;
	logic [NUM_DET-1:0] det_evt;
	logic run;
	logic [7:0] retry;

	assign run = ctrl_q[CTRL_RUN_BIT];
	assign retry = ctrl_q[CTRL_RETRY_LSB +: 8];
	// An err cycle blocks a second take just like an ack cycle
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
		!wb_err_o;
	assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o &&
		!wb_err_o;

	always_comb begin
		mapped = 1'b1;
		rdata = 32'h0000_0000;
		case (wb_adr_i)
			OFF_CTRL: rdata = ctrl_q;
			OFF_ENABLE: rdata = {15'h0000, enable_q};
			OFF_STATUS: rdata = {26'h0, compat_fault, fault_latched, fault_mode,
				faults_q, 1'b0} | {16'h0, min_left_q, 8'h00};
			OFF_IRQ_STAT: rdata = {28'h0, irq_stat_q};
			OFF_IRQ_MASK: rdata = {28'h0, irq_mask_q};
			OFF_MAP_SEL: rdata = {28'h0, map_sel_q};
			OFF_MAP_DATA: rdata = {27'h0, map_q[map_sel_q]};
			OFF_COMPAT_SEL: rdata = {24'h0, cj_q, ci_q};
			OFF_COMPAT_DATA: rdata = {31'h0, (ci_q < cj_q) &&
				compat_q[pair_idx(ci_q, cj_q)]};
			OFF_ERR_SEL: rdata = {27'h0, err_sel_q};
			OFF_ERR_DATA: rdata = (err_sel_q < 5'(NUM_DEV)) ?
				{15'h0, unit_ok[err_sel_q], err_cnt_q[err_sel_q]} : 32'h0;
			OFF_CMD: rdata = 32'h0000_0000;
			default: mapped = 1'b0;
		endcase
	end

	// Single-wait-state slave; unmapped addresses answer with err
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= (wr || rd) && mapped;
			wb_err_o <= (wr || rd) && !mapped;
			wb_dat_o <= rd ? rdata : 32'h0000_0000;
		end
	end

	assign clear_cmd = wr && wb_adr_i == OFF_CMD && wb_sel_i[0] &&
		wb_dat_i[CMD_CLEAR_BIT];

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctrl_q <= CTRL_RESET;
			enable_q <= ENABLE_RESET;
			irq_mask_q <= '0;
			map_sel_q <= '0;
			ci_q <= '0;
			cj_q <= '0;
			err_sel_q <= '0;
		end else if (wr) begin
			case (wb_adr_i)
				OFF_CTRL: begin
					for (int b = 0; b < 4; b++) begin
						if (wb_sel_i[b]) begin
							ctrl_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
						end
					end
				end
				OFF_ENABLE: begin
					if (wb_sel_i[0]) begin
						enable_q[7:0] <= wb_dat_i[7:0];
					end
					if (wb_sel_i[1]) begin
						enable_q[15:8] <= wb_dat_i[15:8];
					end
					if (wb_sel_i[2]) begin
						enable_q[MON_IDX] <= wb_dat_i[MON_IDX];
					end
				end
				OFF_IRQ_MASK: if (wb_sel_i[0]) begin
					irq_mask_q <= wb_dat_i[IRQ_W-1:0];
				end
				OFF_MAP_SEL: if (wb_sel_i[0]) begin
					map_sel_q <= wb_dat_i[3:0];
				end
				OFF_COMPAT_SEL: if (wb_sel_i[0]) begin
					ci_q <= wb_dat_i[3:0];
					cj_q <= wb_dat_i[7:4];
				end
				OFF_ERR_SEL: if (wb_sel_i[0]) begin
					err_sel_q <= wb_dat_i[4:0];
				end
				default: ;
			endcase
		end
	end

	// Map storage; entries above 24 are clamped to zero (identity)
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			for (int m = 0; m < NUM_MCH; m++) begin
				map_q[m] <= 5'h00;
			end
		end else if (wr && wb_adr_i == OFF_MAP_DATA && wb_sel_i[0]) begin
			map_q[map_sel_q] <= (wb_dat_i[4:0] > 5'(NUM_OCH)) ? 5'h00 :
				wb_dat_i[4:0];
		end
	end

	// Only pairs with i<j exist; diagonal or reversed writes are ignored
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			compat_q <= '0;
		end else if (wr && wb_adr_i == OFF_COMPAT_DATA && wb_sel_i[0] &&
			ci_q < cj_q) begin
			compat_q[pair_idx(ci_q, cj_q)] <= wb_dat_i[0];
		end
	end
	assign compat_table = compat_q;

	// Output channel number per monitor channel, 1-based
	genvar g;
	generate
		for (g = 0; g < NUM_MCH; g++) begin : g_map
			assign channel_out[5*g +: 5] = (map_q[g] == 5'h00) ?
				5'(g + 1) : map_q[g];
		end
	endgenerate

	// Units run only when enabled and the run gate is on
	assign unit_active = run ? enable_q : '0;

	// Retry supervisor
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			comm_fault_q <= 1'b0;
		end else begin
			comm_fault_q <= comm_fault && run;
		end
	end
	assign fault_rise = comm_fault && run && !comm_fault_q;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_q <= SFS_IDLE;
			faults_q <= 2'd0;
			min_left_q <= 8'h00;
			tick_q <= '0;
		end else begin
			case (state_q)
				SFS_IDLE: if (fault_rise) begin
					if (retry == 8'h00) begin
						state_q <= SFS_LATCHED;
					end else begin
						state_q <= SFS_FAULT;
						min_left_q <= retry;
						tick_q <= '0;
						faults_q <= 2'd1;
					end
				end
				SFS_FAULT, SFS_WINDOW: begin
					if (tick_q == 40'(MINUTE_CYCLES - 1)) begin
						tick_q <= '0;
						// Stops at zero so an expiry during fault cannot wrap
						if (min_left_q != 8'h00) begin
							min_left_q <= min_left_q - 8'h01;
						end
					end else begin
						tick_q <= tick_q + 40'h1;
					end
					if (fault_rise && faults_q == 2'(FAULT_LIMIT - 1)) begin
						state_q <= SFS_LATCHED;
					end else if (fault_rise) begin
						faults_q <= faults_q + 2'd1;
						state_q <= SFS_FAULT;
					end else if (state_q == SFS_FAULT && !comm_fault) begin
						state_q <= SFS_WINDOW;
					end else if (state_q == SFS_WINDOW &&
						(min_left_q == 8'h00 ||
						(tick_q == 40'(MINUTE_CYCLES - 1) &&
						min_left_q == 8'h01))) begin
						state_q <= SFS_IDLE;
						faults_q <= 2'd0;
					end
				end
				SFS_LATCHED: if (clear_cmd) begin
					state_q <= SFS_IDLE;
					faults_q <= 2'd0;
					min_left_q <= 8'h00;
				end
				default: state_q <= SFS_IDLE;
			endcase
		end
	end

	assign fault_mode = state_q == SFS_FAULT || state_q == SFS_LATCHED;
	assign fault_latched = state_q == SFS_LATCHED;
	assign latch_evt = fault_rise && (state_q == SFS_IDLE ? retry == 8'h00 :
		(state_q != SFS_LATCHED && faults_q == 2'(FAULT_LIMIT - 1)));

	// Compatibility check against the monitor card
	assign compat_fault = run && enable_q[MON_IDX] &&
		(compat_q != monitor_card);
	assign flash_req = compat_fault || fault_mode || !run;

	// Detector fault filter
	assign det_evt = ctrl_q[CTRL_DETREP_BIT] ?
		(det_fault & enable_q[NUM_TF +: NUM_DET]) : '0;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			det_event <= '0;
		end else begin
			det_event <= det_evt;
		end
	end

	// Per-unit frame error counters, saturating
	generate
		for (g = 0; g < NUM_DEV; g++) begin : g_err
			always_ff @(posedge clk) begin
				if (!rst_b) begin
					err_cnt_q[g] <= '0;
				end else if (unit_active[g] && frame_err[g] &&
					err_cnt_q[g] != '1) begin
					err_cnt_q[g] <= err_cnt_q[g] + 16'h0001;
				end
			end
		end
	endgenerate

	// Sticky status, set beats the clear-on-read
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= ((rd && wb_adr_i == OFF_IRQ_STAT) ? '0 : irq_stat_q) |
				{compat_fault, |det_evt, latch_evt, fault_rise};
		end
	end
	assign irq = |(irq_stat_q & irq_mask_q);
endmodule : sfs_supervisor
`default_nettype wire

// File: sfs_pkg.sv
// Constants and types for the cabinet bus fault supervisor
package sfs_pkg;
	localparam int DW = 32;
	localparam int AW = 8;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_ENABLE = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
	localparam logic [7:0] OFF_MAP_SEL = 8'h14;
	localparam logic [7:0] OFF_MAP_DATA = 8'h18;
	localparam logic [7:0] OFF_COMPAT_SEL = 8'h1c;
	localparam logic [7:0] OFF_COMPAT_DATA = 8'h20;
	localparam logic [7:0] OFF_ERR_SEL = 8'h24;
	localparam logic [7:0] OFF_ERR_DATA = 8'h28;
	localparam logic [7:0] OFF_CMD = 8'h2c;
	// CTRL fields
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_DETREP_BIT = 1;
	localparam int CTRL_RETRY_LSB = 8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// CMD fields
	localparam int CMD_CLEAR_BIT = 0;
	// Device enable layout: 8 terminal, 8 detector, 1 monitor
	localparam int NUM_TF = 8;
	localparam int NUM_DET = 8;
	localparam int NUM_DEV = 17;
	localparam int MON_IDX = 16;
	localparam logic [16:0] ENABLE_RESET = 17'h0_0000;
	// Channels
	localparam int NUM_MCH = 16;
	localparam int NUM_OCH = 24;
	localparam int NUM_PAIR = 120;
	localparam int ERR_W = 16;
	// Interrupt bits
	localparam int IRQ_FAULT = 0;
	localparam int IRQ_LATCH = 1;
	localparam int IRQ_DET = 2;
	localparam int IRQ_COMPAT = 3;
	localparam int IRQ_W = 4;
	// Timing: one minute at 250 MHz
	localparam longint CLK_HZ = 250_000_000;
	localparam longint MINUTE_S = 60;
	localparam longint MINUTE_CYC = CLK_HZ * MINUTE_S;
	localparam int FAULT_LIMIT = 3;
	typedef enum logic [1:0] {
		SFS_IDLE,
		SFS_FAULT,
		SFS_WINDOW,
		SFS_LATCHED
	} sfs_state_e;
endpackage : sfs_pkg

// File: sfs_chk.sv
// Assertion checker for the supervisor ports
`timescale 1ns/1ps
`default_nettype none
module sfs_chk (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [sfs_pkg::AW-1:0] wb_adr_i,
	input wire logic [sfs_pkg::DW-1:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire logic [sfs_pkg::NUM_DET-1:0] det_fault,
	input wire logic [sfs_pkg::NUM_DET-1:0] det_event,
	input wire logic fault_latched,
	input wire logic compat_fault,
	input wire logic flash_req,
	input wire logic [5*sfs_pkg::NUM_MCH-1:0] channel_out
);
	import sfs_pkg::*;
	logic clr;
	logic bad;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	assign clr = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] &&
		wb_adr_i == OFF_CMD;
	// Any mapped entry must land on a real output, 1 to 24
	always_comb begin
		bad = 1'b0;
		for (int k = 0; k < NUM_MCH; k++) begin
			if (channel_out[5*k+:5] == 5'h00 || channel_out[5*k+:5] > 5'h18) begin
				bad = 1'b1;
			end
		end
	end
	sequence req_taken;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	endsequence
	chk_ack_due: assert property (req_taken |=> wb_ack_o ^ wb_err_o)
		else $error("request not answered");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	chk_ans_cause: assert property (wb_ack_o || wb_err_o |-> $past(wb_stb_i))
		else $error("answer without request");
	chk_latch_hold: assert property (fault_latched && !clr |=> fault_latched)
		else $error("latch dropped");
	chk_clear_latch: assert property (clr && wb_dat_i[0] && !wb_ack_o |=> !fault_latched)
		else $error("clear ignored");
	chk_compat_flash: assert property (compat_fault |-> flash_req)
		else $error("compat fault without flash");
	chk_det_gate: assert property (det_event != 8'h00 |->
		(det_event & ~$past(det_fault)) == 8'h00)
		else $error("detector event without fault");
	chk_map_range: assert property (!bad)
		else $error("map out of range");
endmodule : sfs_chk
bind sfs_supervisor sfs_chk u_chk (.clk, .rst_b, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_ack_o, .wb_err_o, .det_fault,
	.det_event, .fault_latched, .compat_fault, .flash_req, .channel_out);
`default_nettype wire

// File: sfs_far_model.sv
// Far-side model: cabinet units and malfunction monitor
`timescale 1ns/1ps
`default_nettype none
module sfs_far_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic lose,
	input wire logic [7:0] dset,
	input wire logic [16:0] epl,
	input wire logic [119:0] card,
	output logic comm_fault,
	output logic [7:0] det_fault,
	output logic [16:0] frame_err,
	output logic [16:0] unit_ok,
	output logic [119:0] monitor_card
);
	// Link reduced to a loss level; bit timing is not modelled
	always_ff @(posedge clk) begin
		comm_fault <= rst_b & lose;
		det_fault <= dset;
		frame_err <= epl;
		unit_ok <= ~epl;
		monitor_card <= card;
	end
endmodule : sfs_far_model
`default_nettype wire

// File: test_sfs_supervisor.sv
// Self-checking bench for the cabinet bus fault supervisor
`timescale 1ns/1ps
`default_nettype none
module test_sfs_supervisor;
	import sfs_pkg::*;
	logic clk = 1'b0, rst_b = 1'b0, lose = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00, dset = 8'h00;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic [3:0] wb_sel_i = 4'hf;
	logic wb_ack_o, wb_err_o, comm_fault, fault_mode, fault_latched;
	logic compat_fault, flash_req, irq, be;
	logic [7:0] det_fault, det_event;
	logic [16:0] frame_err, unit_ok, unit_active, epl = 17'h0;
	logic [119:0] monitor_card, compat_table, card = 120'h0;
	logic [79:0] channel_out;
	logic [15:0] lf = 16'he2a2;
	int mismatches = 0, n_checks = 0, k, v, u;
	always #2 clk = ~clk;
	sfs_supervisor #(.MINUTE_CYCLES(10)) u_dut (.clk, .rst_b, .wb_cyc_i,
		.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o,
		.wb_ack_o, .wb_err_o, .comm_fault, .det_fault, .frame_err, .unit_ok,
		.monitor_card, .unit_active, .det_event, .fault_mode, .fault_latched,
		.compat_fault, .flash_req, .compat_table, .channel_out, .irq);
	sfs_far_model u_far (.clk, .rst_b, .lose, .dset, .epl, .card,
		.comm_fault, .det_fault, .frame_err, .unit_ok, .monitor_card);
	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nx
	// Entries past 24 are stored as zero, so they fall back to identity
	function automatic logic [4:0] mexp(input int c, input int e);
		return (e == 0 || e > 24) ? 5'(c + 1) : 5'(e);
	endfunction : mexp
	function automatic int pidx(input int i, input int j);
		return i * 15 - i * (i - 1) / 2 + j - i - 1;
	endfunction : pidx
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
		if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) begin
			mismatches++;
			$display("[FAIL] wb_answer exp 1 got 0");
		end
		q = wb_dat_o;
		be = wb_err_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wbx
	task automatic settle(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : settle
	task automatic flt(input logic on);
		@(posedge clk);
		lose <= on;
		settle(3);
	endtask : flt
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		settle(1);
		chk("flash_rst", 1, flash_req);
		wbx(0, OFF_CTRL, 0);
		chk("ctrl_rst", CTRL_RESET, q);
		wbx(0, 8'h40, 0);
		chk("unmapped", 1, be);
		lf = nx(lf);
		wbx(1, OFF_ENABLE, {15'h0, lf[0], lf});
		settle(1);
		chk("act_off", 0, unit_active);
		wbx(1, OFF_CTRL, 32'h1);
		settle(1);
		chk("act_on", {lf[0], lf}, unit_active);
		$display("test gate done");
		wbx(1, OFF_IRQ_MASK, 32'h1);
		flt(1);
		chk("irq_on", 1, irq);
		flt(0);
		chk("latch0", 1, fault_latched);
		wbx(0, OFF_IRQ_STAT, 0);
		chk("irq_stat", 1, q[IRQ_FAULT]);
		settle(1);
		chk("irq_clr", 0, irq);
		wbx(1, OFF_CMD, 32'h1);
		settle(1);
		chk("clear", 0, fault_latched);
		wbx(1, OFF_CTRL, 32'h0a01);
		for (k = 1; k <= 3; k++) begin
			flt(1);
			chk("fmode", 1, fault_mode);
			flt(0);
			if (k < 3) chk("recover", 0, fault_mode);
			chk("latch3", k == 3, fault_latched);
		end
		wbx(1, OFF_CMD, 32'h1);
		settle(120);
		wbx(1, OFF_CTRL, 32'h0101);
		for (k = 0; k < 3; k++) begin
			flt(1);
			flt(0);
			if (k == 0) settle(40);
		end
		chk("expiry", 0, fault_latched);
		settle(2);
		wbx(0, OFF_STATUS, 0);
		chk("win_end", 0, q[15:0]);
		$display("test retry done");
		lf = nx(lf);
		wbx(1, OFF_ENABLE, {16'h0, lf[15:8] | 8'h01, 8'h00});
		wbx(1, OFF_CTRL, 32'h3);
		dset <= lf[7:0] | 8'h81;
		settle(3);
		v = (lf[7:0] | 8'h81) & (lf[15:8] | 8'h01);
		chk("det_on", v, det_event);
		wbx(1, OFF_CTRL, 32'h1);
		settle(2);
		chk("det_off", 0, det_event);
		for (k = 0; k < 4; k++) begin
			lf = nx(lf);
			u = lf[3:0];
			v = (k < 2) ? 25 * k : lf[8:4] % 25;
			wbx(1, OFF_MAP_SEL, u);
			wbx(1, OFF_MAP_DATA, v);
			settle(1);
			chk("map", mexp(u, v), channel_out[5*u+:5]);
		end
		wbx(1, OFF_ENABLE, 32'h10000);
		wbx(1, OFF_COMPAT_SEL, 32'h52);
		wbx(1, OFF_COMPAT_DATA, 32'h1);
		settle(2);
		chk("ctab", 1, compat_table[pidx(2, 5)]);
		chk("cfault", 1, compat_fault);
		@(posedge clk);
		card[pidx(2, 5)] <= 1'b1;
		settle(3);
		chk("cmatch", 0, compat_fault);
		$display("test map done");
		lf = nx(lf);
		u = lf % 17;
		wbx(1, OFF_ENABLE, 32'h1ffff);
		for (k = 0; k < 3; k++) begin
			@(posedge clk);
			epl <= 17'h1 << u;
			@(posedge clk);
			epl <= 17'h0;
		end
		wbx(1, OFF_ERR_SEL, u);
		wbx(0, OFF_ERR_DATA, 0);
		chk("frame_err", 32'h10003, q[16:0]);
		$display("test errors done");
		flt(1);
		flt(0);
		chk("latch_pre", 1, fault_latched);
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		settle(1);
		chk("latch_rst", 0, fault_latched);
		chk("flash_rst2", 1, flash_req);
		$display("test reset done");
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		end_of_test();
	end
endmodule : test_sfs_supervisor
`default_nettype wire
